// [rsc_pkg.sv]
// Constants, types and helper functions shared by the regulator control logic
package rsc_pkg;

   // Clock rate of mclk
   localparam int unsigned MCLK_KHZ       = 200000;

   // Oscillator frequency per frequency strap code
   localparam int unsigned FSW_KHZ [8]    = '{250, 500, 750, 1000, 1250, 1500, 1750, 2000};
   localparam logic [2:0]  FSEL_250K      = 3'h0;
   localparam logic [2:0]  FSEL_500K      = 3'h1;
   localparam int unsigned SPREAD_PCT     = 10;
   localparam int unsigned SLAVE_HOLD_KHZ = 275;
   localparam int unsigned SLAVE_HOLD_CYC = MCLK_KHZ / SLAVE_HOLD_KHZ;
   localparam int unsigned FAST_PULSES    = 10;

   // Mode/threshold strap fields and codes that need no resistor
   localparam int unsigned MLF_MODE_BIT   = 2;
   localparam logic [2:0]  MLF_LNM_93     = 3'h2;
   localparam logic [2:0]  MLF_LCM_93     = 3'h6;
   localparam logic [1:0]  THR_80_IDX     = 2'h0;
   localparam logic [1:0]  THR_87_IDX     = 2'h1;
   localparam logic [1:0]  THR_93_IDX     = 2'h2;
   localparam logic [1:0]  THR_96_IDX     = 2'h3;

   // Strap sampling window after power-up, least time
   localparam int unsigned STRAP_NS       = 1000;
   localparam int unsigned STRAP_CYC      = (STRAP_NS * MCLK_KHZ + 999999) / 1000000;

   // Reset delay ramp: capacitor charged by a current source to a trip level
   localparam int unsigned DELAY_CAP_NF   = 10;
   localparam int unsigned DELAY_I_NA     = 2000;
   localparam int unsigned DELAY_TRIP_MV  = 1234;
   localparam int unsigned DELAY_US       = DELAY_CAP_NF * DELAY_TRIP_MV * 1000 / DELAY_I_NA;
   localparam int unsigned DELAY_CYC      = DELAY_US * (MCLK_KHZ / 1000);

   typedef enum logic [2:0] {
      RSC_ST_STRAP   = 3'h0,
      RSC_ST_MASTER  = 3'h1,
      RSC_ST_SLAVE   = 3'h2,
      RSC_ST_PROBE   = 3'h3,
      RSC_ST_LATCHED = 3'h4
   } rsc_mode_t;

   typedef enum logic [1:0] {
      RSC_SUP_HOLD  = 2'h0,
      RSC_SUP_DELAY = 2'h1,
      RSC_SUP_GOOD  = 2'h2
   } rsc_sup_t;

   // Oscillator period in mclk cycles
   function automatic logic [15:0] rsc_per_cyc(input logic [2:0] code);
      rsc_per_cyc = 16'(MCLK_KHZ / FSW_KHZ[code]);
   endfunction

   // Longest sync interval still faster than the oscillator's top spread
   function automatic logic [15:0] rsc_fast_cyc(input logic [2:0] code);
      rsc_fast_cyc = 16'((MCLK_KHZ * 100) / (FSW_KHZ[code] * (100 + SPREAD_PCT)));
   endfunction

endpackage

// [rsc_sync2.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rsc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// [rsc_link.sv]
// Sync line logic on the link clock: edge capture and pin drive
`timescale 1ns/1ps
module rsc_link (
   // Link clock and reset
   input  wire logic link_clk,
   input  wire logic nrst,
   // Sync line pin
   input  wire logic sync_line_i,
   output logic      sync_line_o,
   output logic      sync_line_oe,
   // To and from the mclk domain
   input  wire logic drive_lvl,
   input  wire logic drive_en,
   output logic      edge_tgl
);
   logic       pin_s;
   logic       pin_prev_q;
   logic [1:0] drv_s;

   rsc_sync2 #(.W(1)) u_pin_sync (
      .clk  (link_clk),
      .nrst (nrst),
      .d    (sync_line_i),
      .q    (pin_s)
   );

   rsc_sync2 #(.W(2)) u_drv_sync (
      .clk  (link_clk),
      .nrst (nrst),
      .d    ({drive_en, drive_lvl}),
      .q    (drv_s)
   );

   // Rising edges of the line become toggles for the other domain
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         pin_prev_q <= 1'b0;
         edge_tgl   <= 1'b0;
      end else begin
         pin_prev_q <= pin_s;
         if (pin_s && !pin_prev_q) begin
            edge_tgl <= ~edge_tgl;
         end
      end
   end

   // Pin drive
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         sync_line_o  <= 1'b0;
         sync_line_oe <= 1'b0;
      end else begin
         sync_line_o  <= drv_s[0];
         sync_line_oe <= drv_s[1];
      end
   end
endmodule

// [rsc_ctrl.sv]
// Strap capture, output supervisor and sync line mode control of the regulator
`timescale 1ns/1ps
module rsc_ctrl #(
   parameter int unsigned DELAY_CYC = rsc_pkg::DELAY_CYC,
   parameter int          DLY_W     = 24,
   parameter int          CNT_W     = 16
) (
   // Clocks and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       link_clk,
   // Frequency select strap
   input  wire logic [2:0] freq_select_strap_code,
   output logic            freq_select_strap_oe,
   // Mode/threshold strap
   input  wire logic [2:0] mode_threshold_strap_code,
   output logic            mode_threshold_strap_oe,
   // Supervisor comparators on the feedback sense, one per threshold
   input  wire logic [3:0] feedback_sense_ok,
   // Sync line
   input  wire logic       sync_line_i,
   output logic            sync_line_o,
   output logic            sync_line_oe,
   input  wire logic       sync_ext_ref,
   // Latched configuration, and the oscillator code that follows the mode
   output logic [2:0]      fsw_sel,
   output logic [2:0]      slope_comp_sel,
   output logic            low_noise_operation,
   output logic            low_consumption_operation,
   output logic [1:0]      rst_thr_sel,
   // Operation
   output logic            softstart_en,
   output logic            osc_clk,
   output logic            slave_mode,
   output logic            slave_latched,
   // Power-good reset, open drain
   output logic            pg_reset_o,
   output logic            pg_reset_oe
);
   localparam logic [CNT_W-1:0] STRAP_LAST = CNT_W'(rsc_pkg::STRAP_CYC - 1);
   localparam logic [CNT_W-1:0] HOLD_CYC   = CNT_W'(rsc_pkg::SLAVE_HOLD_CYC);
   localparam logic [3:0]       FAST_LAST  = 4'(rsc_pkg::FAST_PULSES - 1);
   localparam logic [DLY_W-1:0] DLY_LAST   = DLY_W'(DELAY_CYC - 1);

   // Synchronised pin inputs
   logic [11:0]           pins_s;
   logic [2:0]            fsel_s;
   logic [2:0]            mlf_s;
   logic [3:0]            fb_s;
   logic                  line_s;
   logic                  tgl_s;
   logic                  link_tgl;

   // State
   logic [CNT_W-1:0]      strap_cnt_q;
   rsc_pkg::rsc_mode_t    mode_q;
   rsc_pkg::rsc_mode_t    mode_d;
   logic                  tgl_prev_q;
   logic                  ext_edge;
   logic [CNT_W-1:0]      ivl_q;
   logic [3:0]            fast_q;
   logic [CNT_W-1:0]      osc_cnt_q;
   logic [CNT_W-1:0]      osc_cnt_d;
   logic [CNT_W-1:0]      per_cyc;
   logic [CNT_W-1:0]      half_cyc;
   logic                  osc_wrap;
   logic                  drive_lvl_q;
   logic                  drive_en_q;
   rsc_pkg::rsc_sup_t     sup_q;
   logic [DLY_W-1:0]      dly_q;
   logic                  fb_ok;
   logic                  fast_ivl;
   logic                  strap_end;

   rsc_sync2 #(.W(12)) u_pin_sync (
      .clk  (mclk),
      .nrst (nrst),
      .d    ({link_tgl, sync_line_i, feedback_sense_ok,
              mode_threshold_strap_code, freq_select_strap_code}),
      .q    (pins_s)
   );

   assign fsel_s = pins_s[2:0];
   assign mlf_s  = pins_s[5:3];
   assign fb_s   = pins_s[9:6];
   assign line_s = pins_s[10];
   assign tgl_s  = pins_s[11];

   rsc_link u_link (
      .link_clk     (link_clk),
      .nrst         (nrst),
      .sync_line_i  (sync_line_i),
      .sync_line_o  (sync_line_o),
      .sync_line_oe (sync_line_oe),
      .drive_lvl    (drive_lvl_q),
      .drive_en     (drive_en_q),
      .edge_tgl     (link_tgl)
   );

   assign strap_end = (mode_q == rsc_pkg::RSC_ST_STRAP) && (strap_cnt_q == STRAP_LAST);

   // Strap window: bias the strap pins, count, then release them
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strap_cnt_q             <= '0;
         freq_select_strap_oe    <= 1'b1;
         mode_threshold_strap_oe <= 1'b1;
         softstart_en            <= 1'b0;
      end else if (mode_q == rsc_pkg::RSC_ST_STRAP) begin
         strap_cnt_q <= strap_cnt_q + 1'b1;
         if (strap_end) begin
            freq_select_strap_oe    <= 1'b0;
            mode_threshold_strap_oe <= 1'b0;
            softstart_en            <= 1'b1;
         end
      end
   end

   // Latch strap settings once, before soft-start; defaults need no resistor
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slope_comp_sel            <= rsc_pkg::FSEL_500K;
         low_noise_operation       <= 1'b1;
         low_consumption_operation <= 1'b0;
         rst_thr_sel               <= rsc_pkg::MLF_LNM_93[1:0];
         slave_latched             <= 1'b0;
      end else if (strap_end) begin
         slope_comp_sel            <= fsel_s;
         low_noise_operation       <= !mlf_s[rsc_pkg::MLF_MODE_BIT];
         low_consumption_operation <= mlf_s[rsc_pkg::MLF_MODE_BIT];
         rst_thr_sel               <= mlf_s[1:0];
         slave_latched             <= !line_s;
      end
   end

   // Oscillator code: latched slave ignores the frequency strap
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fsw_sel <= rsc_pkg::FSEL_500K;
      end else if (strap_end) begin
         fsw_sel <= line_s ? fsel_s : rsc_pkg::FSEL_250K;
      end else if (mode_d == rsc_pkg::RSC_ST_MASTER) begin
         fsw_sel <= slope_comp_sel;
      end else if (mode_d != rsc_pkg::RSC_ST_STRAP) begin
         fsw_sel <= rsc_pkg::FSEL_250K;
      end
   end

   // Rising edges of the sync line from the link domain
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tgl_prev_q <= 1'b0;
      end else begin
         tgl_prev_q <= tgl_s;
      end
   end

   assign ext_edge = tgl_s ^ tgl_prev_q;

   // Interval since the last rising edge, saturating
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ivl_q <= '0;
      end else if (ext_edge) begin
         ivl_q <= '0;
      end else if (ivl_q != '1) begin
         ivl_q <= ivl_q + 1'b1;
      end
   end

   assign fast_ivl = (ivl_q < rsc_pkg::rsc_fast_cyc(slope_comp_sel));

   // Run of consecutive pulses faster than the top oscillator spread
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fast_q <= '0;
      end else if (mode_q != rsc_pkg::RSC_ST_MASTER) begin
         fast_q <= '0;
      end else if (ext_edge) begin
         if (fast_ivl) begin
            fast_q <= fast_q + 1'b1;
         end else begin
            fast_q <= '0;
         end
      end
   end

   // Mode control
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         rsc_pkg::RSC_ST_STRAP: begin
            if (strap_end) begin
               mode_d = line_s ? rsc_pkg::RSC_ST_MASTER : rsc_pkg::RSC_ST_LATCHED;
            end
         end
         rsc_pkg::RSC_ST_MASTER: begin
            if (ext_edge && fast_ivl && (fast_q == FAST_LAST)) begin
               mode_d = rsc_pkg::RSC_ST_SLAVE;
            end
         end
         rsc_pkg::RSC_ST_SLAVE: begin
            if (!ext_edge && (ivl_q >= HOLD_CYC)) begin
               mode_d = rsc_pkg::RSC_ST_PROBE;
            end
         end
         rsc_pkg::RSC_ST_PROBE: begin
            if (osc_wrap) begin
               mode_d = rsc_pkg::RSC_ST_MASTER;
            end
         end
         rsc_pkg::RSC_ST_LATCHED: begin
            mode_d = rsc_pkg::RSC_ST_LATCHED;
         end
         default: begin
            mode_d = rsc_pkg::RSC_ST_STRAP;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_q     <= rsc_pkg::RSC_ST_STRAP;
         slave_mode <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         slave_mode <= (mode_d == rsc_pkg::RSC_ST_SLAVE) ||
                       (mode_d == rsc_pkg::RSC_ST_LATCHED);
      end
   end

   // Oscillator period and phase
   assign per_cyc  = rsc_pkg::rsc_per_cyc(fsw_sel);
   assign half_cyc = per_cyc >> 1;
   assign osc_wrap = (osc_cnt_q >= per_cyc - 1'b1);

   always_comb begin
      osc_cnt_d = osc_wrap ? '0 : osc_cnt_q + 1'b1;
      if (mode_q == rsc_pkg::RSC_ST_STRAP) begin
         osc_cnt_d = '0;
      end else if (mode_q == rsc_pkg::RSC_ST_SLAVE && mode_d == rsc_pkg::RSC_ST_PROBE) begin
         osc_cnt_d = '0;
      end else if (ext_edge && ((mode_q == rsc_pkg::RSC_ST_SLAVE) ||
                                (mode_q == rsc_pkg::RSC_ST_LATCHED))) begin
         if (sync_ext_ref || slave_latched) begin
            osc_cnt_d = '0;
         end else begin
            osc_cnt_d = half_cyc;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         osc_cnt_q <= '0;
      end else begin
         osc_cnt_q <= osc_cnt_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         osc_clk <= 1'b0;
      end else begin
         osc_clk <= (mode_q != rsc_pkg::RSC_ST_STRAP) && (osc_cnt_d < half_cyc);
      end
   end

   // Sync line drive: master, and the single return pulse in probe
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         drive_lvl_q <= 1'b0;
         drive_en_q  <= 1'b0;
      end else begin
         case (mode_d)
            rsc_pkg::RSC_ST_MASTER: begin
               drive_en_q  <= 1'b1;
               drive_lvl_q <= osc_cnt_d < half_cyc;
            end
            rsc_pkg::RSC_ST_PROBE: begin
               drive_en_q  <= 1'b1;
               drive_lvl_q <= osc_cnt_d < half_cyc;
            end
            default: begin
               drive_en_q  <= 1'b0;
               drive_lvl_q <= 1'b0;
            end
         endcase
      end
   end

   // Supervisor
   assign fb_ok = fb_s[rst_thr_sel];

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sup_q <= rsc_pkg::RSC_SUP_HOLD;
         dly_q <= '0;
      end else begin
         case (sup_q)
            rsc_pkg::RSC_SUP_HOLD: begin
               dly_q <= '0;
               if (softstart_en && fb_ok) begin
                  sup_q <= rsc_pkg::RSC_SUP_DELAY;
               end
            end
            rsc_pkg::RSC_SUP_DELAY: begin
               if (!fb_ok) begin
                  sup_q <= rsc_pkg::RSC_SUP_HOLD;
                  dly_q <= '0;
               end else if (dly_q == DLY_LAST) begin
                  sup_q <= rsc_pkg::RSC_SUP_GOOD;
               end else begin
                  dly_q <= dly_q + 1'b1;
               end
            end
            rsc_pkg::RSC_SUP_GOOD: begin
               if (!fb_ok) begin
                  sup_q <= rsc_pkg::RSC_SUP_HOLD;
               end
            end
            default: begin
               sup_q <= rsc_pkg::RSC_SUP_HOLD;
               dly_q <= '0;
            end
         endcase
      end
   end

   // Open-drain reset pin: pulled low unless good
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pg_reset_o  <= 1'b0;
         pg_reset_oe <= 1'b1;
      end else begin
         pg_reset_o  <= 1'b0;
         pg_reset_oe <= !((sup_q == rsc_pkg::RSC_SUP_DELAY && fb_ok && dly_q == DLY_LAST) ||
                          (sup_q == rsc_pkg::RSC_SUP_GOOD && fb_ok));
      end
   end

endmodule

// [rsc_ctrl_checker.sv]
// Port assertions for the regulator strap, supervisor and sync control
`timescale 1ns/1ps
module rsc_ctrl_checker #(
   parameter int unsigned DELAY_CYC = 50
) (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       nrst,
   // Straps and latched configuration
   input wire logic       freq_select_strap_oe,
   input wire logic       mode_threshold_strap_oe,
   input wire logic [2:0] slope_comp_sel,
   input wire logic       low_noise_operation,
   input wire logic       low_consumption_operation,
   input wire logic [1:0] rst_thr_sel,
   // Operation
   input wire logic       softstart_en,
   input wire logic [2:0] fsw_sel,
   input wire logic       slave_mode,
   input wire logic       slave_latched,
   // Supervisor
   input wire logic [3:0] feedback_sense_ok,
   input wire logic       pg_reset_o,
   input wire logic       pg_reset_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // Cycles the selected comparator has been high without a break
   logic [31:0] ok_cnt_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ok_cnt_q <= 32'h0;
      end else if (!feedback_sense_ok[rst_thr_sel]) begin
         ok_cnt_q <= 32'h0;
      end else if (ok_cnt_q < DELAY_CYC + 8) begin
         ok_cnt_q <= ok_cnt_q + 32'h1;
      end
   end

   chk_strap_float: assert property (softstart_en |-> !freq_select_strap_oe && !mode_threshold_strap_oe)
      else $error("strap pin still driven after soft-start");
   chk_strap_before_ss: assert property ($fell(freq_select_strap_oe) |-> ##[0:2] softstart_en)
      else $error("soft-start did not follow strap sampling");
   chk_reset_hold: assert property (!softstart_en |-> pg_reset_oe)
      else $error("reset released before soft-start");
   chk_reset_level: assert property (pg_reset_o == 1'b0)
      else $error("reset output driven high");
   chk_release_delay: assert property ($fell(pg_reset_oe) |-> ok_cnt_q >= DELAY_CYC)
      else $error("reset released before delay ran out");
   chk_loss_reassert: assert property (!pg_reset_oe && !feedback_sense_ok[rst_thr_sel]
                                       |-> ##[1:5] pg_reset_oe)
      else $error("reset not reasserted on loss of regulation");
   chk_slope_fixed: assert property (softstart_en && $past(softstart_en) |-> $stable(slope_comp_sel))
      else $error("slope setting changed");
   chk_cfg_fixed: assert property (softstart_en && $past(softstart_en)
                                   |-> $stable({rst_thr_sel, low_noise_operation}))
      else $error("mode or threshold changed");
   chk_mode_onehot: assert property (softstart_en |-> low_noise_operation ^ low_consumption_operation)
      else $error("mode outputs not exclusive");
   chk_slave_osc: assert property (slave_mode |-> fsw_sel == rsc_pkg::FSEL_250K)
      else $error("slave oscillator not at 250 kHz");
   chk_latch_hold: assert property (slave_latched |=> slave_latched && slave_mode)
      else $error("latched slave mode left");

   cov_release: cover property ($fell(pg_reset_oe));
   cov_to_slave: cover property ($rose(slave_mode));
   cov_to_master: cover property ($fell(slave_mode));
   cov_latched: cover property (slave_latched);
endmodule

bind rsc_ctrl rsc_ctrl_checker #(.DELAY_CYC(DELAY_CYC)) u_chk (
   .mclk, .nrst, .freq_select_strap_oe, .mode_threshold_strap_oe, .slope_comp_sel,
   .low_noise_operation, .low_consumption_operation, .rst_thr_sel, .softstart_en,
   .fsw_sel, .slave_mode, .slave_latched, .feedback_sense_ok, .pg_reset_o, .pg_reset_oe
);

// [rsc_sync_partner.sv]
// Model of an external sync source on the sync line
`timescale 1ns/1ps
module rsc_sync_partner #(
   parameter int unsigned PERIOD = 350
) (
   // Clock
   input  wire logic mclk,
   // Bench control
   input  wire logic run,
   input  wire logic hold_low,
   // Line drive
   output logic      drv_o,
   output logic      drv_oe
);
   logic [15:0] cnt_q = 16'h0;
   logic [15:0] cnt_d;
   // Fixed period: 571 kHz, inside 20% of 500 kHz, kept up for many cycles
   assign cnt_d = (!run || cnt_q == 16'(PERIOD - 1)) ? 16'h0 : cnt_q + 16'h1;
   always_ff @(posedge mclk) begin
      cnt_q <= cnt_d;
   end
   // High for half the period, far above 100 ns
   assign drv_o  = run && (cnt_q < 16'(PERIOD / 2));
   // Held low at power-up to force latched slave mode; one strap for all
   assign drv_oe = run || hold_low;
endmodule

// [test_regulator_sync_and_supervisor_ctrl.sv]
// Self-checking bench for the regulator strap, supervisor and sync control
`timescale 1ns/1ps
module test_regulator_sync_and_supervisor_ctrl;
   localparam int unsigned DLY = 50;
   logic       mclk, nrst, link_clk, sync_line_i, sync_line_o, sync_line_oe, sync_ext_ref;
   logic [2:0] freq_select_strap_code, mode_threshold_strap_code, fsw_sel, slope_comp_sel;
   logic       freq_select_strap_oe, mode_threshold_strap_oe, softstart_en, osc_clk;
   logic       low_noise_operation, low_consumption_operation, slave_mode, slave_latched;
   logic [3:0] feedback_sense_ok;
   logic [1:0] rst_thr_sel;
   logic       pg_reset_o, pg_reset_oe, p_run, p_low, p_o, p_oe;
   int         error_cnt = 0;
   int         check_count = 0;

   // Line with pull-up: partner overrides, else device drive
   assign sync_line_i = p_oe ? p_o : (sync_line_oe ? sync_line_o : 1'b1);

   rsc_ctrl #(.DELAY_CYC(DLY)) dut (
      .mclk, .nrst, .link_clk, .freq_select_strap_code, .freq_select_strap_oe,
      .mode_threshold_strap_code, .mode_threshold_strap_oe, .feedback_sense_ok,
      .sync_line_i, .sync_line_o, .sync_line_oe, .sync_ext_ref, .fsw_sel, .slope_comp_sel,
      .low_noise_operation, .low_consumption_operation, .rst_thr_sel, .softstart_en,
      .osc_clk, .slave_mode, .slave_latched, .pg_reset_o, .pg_reset_oe
   );
   rsc_sync_partner #(.PERIOD(350)) u_partner (
      .mclk, .run(p_run), .hold_low(p_low), .drv_o(p_o), .drv_oe(p_oe)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic smp(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   function automatic logic sig(input bit ln);
      return ln ? sync_line_i : osc_clk;
   endfunction
   // Cycles between two rising edges of the oscillator or of the line
   task automatic meas(input bit ln, output int per);
      int i;
      for (i = 0; i < 2000 && sig(ln) !== 1'b0; i++) @(negedge mclk);
      for (i = 0; i < 2000 && sig(ln) !== 1'b1; i++) @(negedge mclk);
      for (per = 0; per < 2000 && sig(ln) !== 1'b0; per++) @(negedge mclk);
      for (; per < 2000 && sig(ln) !== 1'b1; per++) @(negedge mclk);
   endtask
   task automatic do_reset(input logic [2:0] f, input logic [2:0] m, input logic low);
      @(posedge mclk);
      nrst <= 1'b0;
      freq_select_strap_code <= f;
      mode_threshold_strap_code <= m;
      feedback_sense_ok <= 4'h0;
      sync_ext_ref <= 1'b0;
      p_run <= 1'b0;
      p_low <= low;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      smp(1);
      chk(freq_select_strap_oe, 1'b1);
      chk(pg_reset_oe, 1'b1);
      smp(rsc_pkg::STRAP_CYC + 4);
      chk(freq_select_strap_oe, 1'b0);
      chk(mode_threshold_strap_oe, 1'b0);
      chk(softstart_en, 1'b1);
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      end_of_test;
   end

   initial begin
      int   per, i;
      logic seen;
      nrst = 1'b0;
      freq_select_strap_code = 3'h0;
      mode_threshold_strap_code = 3'h0;
      feedback_sense_ok = 4'h0;
      sync_ext_ref = 1'b0;
      p_run = 1'b0;
      p_low = 1'b0;
      do_reset(rsc_pkg::FSEL_500K, rsc_pkg::MLF_LCM_93, 1'b0);
      chk(slope_comp_sel, 3'h1);
      chk(low_consumption_operation, 1'b1);
      chk(rst_thr_sel, rsc_pkg::THR_93_IDX);
      @(posedge mclk);
      freq_select_strap_code <= 3'h5;
      meas(1'b0, per);
      chk(per[15:0], 16'd400);
      chk(fsw_sel, 3'h1);
      meas(1'b1, per);
      chk(per >= 398 && per <= 402, 1'b1);
      // Supervisor: wrong comparator, broken delay, then full delay
      @(posedge mclk) feedback_sense_ok <= 4'hb;
      smp(DLY + 20);
      chk(pg_reset_oe, 1'b1);
      @(posedge mclk) feedback_sense_ok <= 4'h4;
      smp(DLY / 2);
      @(posedge mclk) feedback_sense_ok <= 4'h0;
      smp(3);
      @(posedge mclk) feedback_sense_ok <= 4'h4;
      smp(DLY);
      chk(pg_reset_oe, 1'b1);
      smp(8);
      chk(pg_reset_oe, 1'b0);
      @(posedge mclk) feedback_sense_ok <= 4'h0;
      smp(5);
      chk(pg_reset_oe, 1'b1);
      // Sync line: fast external pulses make a slave
      @(posedge mclk) p_run <= 1'b1;
      smp(350 * 8);
      chk(slave_mode, 1'b0);
      for (i = 0; i < 3000 && slave_mode !== 1'b1; i++) @(negedge mclk);
      chk(slave_mode, 1'b1);
      chk(fsw_sel, rsc_pkg::FSEL_250K);
      smp(400);
      for (i = 0; i < 4; i++) begin
         smp(97);
         chk(osc_clk, 1'b0);
      end
      @(posedge mclk) sync_ext_ref <= 1'b1;
      smp(400);
      for (i = 0; i < 4; i++) begin
         smp(97);
         chk(osc_clk, 1'b1);
      end
      chk(slave_mode, 1'b1);
      // Line goes quiet: one own pulse, then master again
      @(posedge mclk) p_run <= 1'b0;
      seen = 1'b0;
      for (i = 0; i < 4000 && fsw_sel !== 3'h1; i++) begin
         @(negedge mclk);
         if (sync_line_oe === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(i >= 1100, 1'b1);
      chk(fsw_sel, 3'h1);
      do_reset(rsc_pkg::FSEL_250K, rsc_pkg::MLF_LNM_93, 1'b0);
      chk(slope_comp_sel, 3'h0);
      chk(low_noise_operation, 1'b1);
      chk(slave_mode, 1'b0);
      // Line low at power-up latches slave mode
      do_reset(3'h2, 3'h4, 1'b1);
      chk(slave_latched, 1'b1);
      chk(fsw_sel, 3'h0);
      chk(slope_comp_sel, 3'h2);
      chk(rst_thr_sel, rsc_pkg::THR_80_IDX);
      @(posedge mclk) p_low <= 1'b0;
      smp(1000);
      chk(slave_latched, 1'b1);
      meas(1'b0, per);
      chk(per[15:0], 16'd800);
      end_of_test;
   end
endmodule
